/* design/sra_pkg.sv */
package sra_pkg;

  // serial word geometry
  localparam int WORD_W = 16;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_FIRST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'hf;

  // command word layout
  localparam int CMD_EN_HI = 15;
  localparam int CMD_EN_LO = 11;
  localparam int CMD_EN_W = CMD_EN_HI - CMD_EN_LO + 1;
  localparam logic [CMD_EN_W-1:0] CMD_EN_PATTERN = 5'h1c;
  localparam int CMD_DIR_BIT = 10;
  localparam int ADDR_W = 10;
  localparam int ADDR_HI = ADDR_W - 1;
  localparam int ADDR_LO = 0;
  localparam logic CMD_DIR_READ = 1'b1;

  // register map size and reset contents
  localparam int REG_COUNT_DEF = 1024;
  localparam logic [WORD_W-1:0] REG_RESET = 16'h0000;

  // events carried from the serial clock into the system clock
  localparam int EV_N = 3;
  localparam int EV_WRITE = 0;
  localparam int EV_REJECT = 1;
  localparam int EV_DROP = 2;

endpackage

/* design/sra_spi_slave.sv */
`timescale 1ns/10ps
`default_nettype none

module sra_spi_slave #(
  parameter int REG_COUNT = sra_pkg::REG_COUNT_DEF
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic frame_active_o,
  output logic wr_valid_o,
  output logic [sra_pkg::ADDR_W-1:0] wr_addr_o,
  output logic [sra_pkg::WORD_W-1:0] wr_data_o,
  output logic cmd_reject_o,
  output logic wr_drop_o
);

  localparam int PTR_W = sra_pkg::ADDR_W;
  localparam logic [sra_pkg::ADDR_W-1:0] PTR_MAX = PTR_W'(REG_COUNT - 1);

  // ---------------------------------------------------------------
  // link side, serial clock domain
  // chip select high clears all frame state asynchronously, so no
  // edge of the serial clock is needed after a frame ends
  // ---------------------------------------------------------------

  logic [sra_pkg::CNT_W-1:0] bit_cnt_q;
  logic [sra_pkg::WORD_W-2:0] in_sh_q;
  logic cmd_done_q;
  logic cmd_ok_q;
  logic rd_q;
  logic stop_q;
  logic [sra_pkg::ADDR_W-1:0] ptr_q;
  logic [sra_pkg::WORD_W-1:0] regs_q [REG_COUNT];
  logic [sra_pkg::WORD_W-1:0] out_sh_q;
  logic out_en_q;
  logic [sra_pkg::ADDR_W-1:0] hold_addr_q;
  logic [sra_pkg::WORD_W-1:0] hold_data_q;
  logic [sra_pkg::EV_N-1:0] ev_tgl_q;

  logic word_end;
  logic [sra_pkg::WORD_W-1:0] word_w;
  logic cmd_end;
  logic cmd_take;
  logic cmd_bad;
  logic data_word;
  logic wr_fire;
  logic wr_lost;
  logic [sra_pkg::EV_N-1:0] ev_fire;

  function automatic logic cmd_enabled(input logic [sra_pkg::WORD_W-1:0] w);
    cmd_enabled = (w[sra_pkg::CMD_EN_HI:sra_pkg::CMD_EN_LO] == sra_pkg::CMD_EN_PATTERN);
  endfunction

  assign word_end = (bit_cnt_q == sra_pkg::CNT_LAST);
  assign word_w = {in_sh_q, sdi_i};
  assign cmd_end = word_end & ~cmd_done_q;
  assign cmd_take = cmd_end & cmd_enabled(word_w);
  assign cmd_bad = cmd_end & ~cmd_enabled(word_w);
  assign data_word = word_end & cmd_done_q & cmd_ok_q;
  assign wr_fire = data_word & ~rd_q & ~stop_q;
  assign wr_lost = data_word & ~rd_q & stop_q;
  assign ev_fire = {wr_lost, cmd_bad, wr_fire};

  // input shifting on the rising edge; either idle level is fine since
  // the count only moves on rising edges inside a selected frame
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_q <= sra_pkg::CNT_FIRST;
    end else begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      in_sh_q <= '0;
    end else begin
      in_sh_q <= word_w[sra_pkg::WORD_W-2:0];
    end
  end

  // the first word of each frame is the command
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cmd_done_q <= 1'b0;
    end else if (cmd_end) begin
      cmd_done_q <= 1'b1;
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cmd_ok_q <= 1'b0;
    end else if (cmd_end) begin
      cmd_ok_q <= cmd_enabled(word_w);
    end
  end

  // direction is kept even for a rejected command; cmd_ok_q gates its use
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rd_q <= 1'b0;
    end else if (cmd_end) begin
      rd_q <= (word_w[sra_pkg::CMD_DIR_BIT] == sra_pkg::CMD_DIR_READ);
    end
  end

  // address pointer: loaded by the command, stepped after every data
  // word, parked at the top address
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      ptr_q <= '0;
    end else if (cmd_take) begin
      ptr_q <= word_w[sra_pkg::ADDR_HI:sra_pkg::ADDR_LO];
    end else if (data_word && (ptr_q != PTR_MAX)) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // a write that lands on the top address still stores; only the words
  // after it are dropped
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      stop_q <= 1'b0;
    end else if (data_word && !rd_q && (ptr_q == PTR_MAX)) begin
      stop_q <= 1'b1;
    end
  end

  // register storage lives on the serial clock so read data is ready
  // on the falling edge straight after the command; the system side
  // sees writes only through the event crossing below
  always_ff @(posedge sclk_i or posedge srst_i) begin
    if (srst_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= sra_pkg::REG_RESET;
      end
    end else if (wr_fire) begin
      regs_q[ptr_q] <= word_w;
    end
  end

  // copy of the last write, held steady until the next write so the
  // system side can pick it up after the toggle has crossed
  always_ff @(posedge sclk_i or posedge srst_i) begin
    if (srst_i) begin
      hold_addr_q <= '0;
    end else if (wr_fire) begin
      hold_addr_q <= ptr_q;
    end
  end

  always_ff @(posedge sclk_i or posedge srst_i) begin
    if (srst_i) begin
      hold_data_q <= '0;
    end else if (wr_fire) begin
      hold_data_q <= word_w;
    end
  end

  // one toggle per event kind; toggles survive the end of a frame
  always_ff @(posedge sclk_i or posedge srst_i) begin
    if (srst_i) begin
      ev_tgl_q <= '0;
    end else begin
      ev_tgl_q <= ev_tgl_q ^ ev_fire;
    end
  end

  // output shifting on the falling edge; a new word is fetched whenever
  // the bit count is back at zero, which is after the command and after
  // each read word, at the address that the rising edge just settled
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_sh_q <= '0;
    end else if (bit_cnt_q == sra_pkg::CNT_FIRST) begin
      out_sh_q <= regs_q[ptr_q];
    end else begin
      out_sh_q <= {out_sh_q[sra_pkg::WORD_W-2:0], 1'b0};
    end
  end

  // drive only inside an accepted read, from the first falling edge
  // after the command until chip select rises
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_en_q <= 1'b0;
    end else begin
      out_en_q <= cmd_done_q & cmd_ok_q & rd_q;
    end
  end

  assign sdo_o = out_sh_q[sra_pkg::WORD_W-1];
  assign sdo_oe_o = out_en_q;

  // ---------------------------------------------------------------
  // system side, mclk domain
  // ---------------------------------------------------------------

  logic [sra_pkg::EV_N-1:0] ev_s1_q;
  logic [sra_pkg::EV_N-1:0] ev_s2_q;
  logic [sra_pkg::EV_N-1:0] ev_s3_q;
  logic [sra_pkg::EV_N-1:0] ev_pulse_q;
  logic cs_s1_q;
  logic cs_s2_q;
  logic frame_q;
  logic [sra_pkg::ADDR_W-1:0] wr_addr_q;
  logic [sra_pkg::WORD_W-1:0] wr_data_q;
  logic wr_seen;

  assign wr_seen = (ev_s2_q[sra_pkg::EV_WRITE] != ev_s3_q[sra_pkg::EV_WRITE]);

  // a write word takes 16 serial clocks, longer than the three system
  // clocks this crossing needs, so toggles never fold together
  genvar g;
  generate
    for (g = 0; g < sra_pkg::EV_N; g++) begin : g_ev
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          ev_s1_q[g] <= 1'b0;
          ev_s2_q[g] <= 1'b0;
          ev_s3_q[g] <= 1'b0;
          ev_pulse_q[g] <= 1'b0;
        end else begin
          ev_s1_q[g] <= ev_tgl_q[g];
          ev_s2_q[g] <= ev_s1_q[g];
          ev_s3_q[g] <= ev_s2_q[g];
          ev_pulse_q[g] <= ev_s2_q[g] ^ ev_s3_q[g];
        end
      end
    end
  endgenerate

  // the hold registers have been steady for two system clocks by the
  // time the toggle shows, so they are sampled as a settled word
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_addr_q <= '0;
    end else if (wr_seen) begin
      wr_addr_q <= hold_addr_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_data_q <= '0;
    end else if (wr_seen) begin
      wr_data_q <= hold_data_q;
    end
  end

  // chip select is a pin: two flops before the frame flag reads it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= ~cs_s2_q;
    end
  end

  assign frame_active_o = frame_q;
  assign wr_valid_o = ev_pulse_q[sra_pkg::EV_WRITE];
  assign wr_addr_o = wr_addr_q;
  assign wr_data_o = wr_data_q;
  assign cmd_reject_o = ev_pulse_q[sra_pkg::EV_REJECT];
  assign wr_drop_o = ev_pulse_q[sra_pkg::EV_DROP];

endmodule

`default_nettype wire

/* testbench/sra_spi_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module sra_spi_monitor (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic sdo_oe_o,
  input wire logic frame_active_o,
  input wire logic wr_valid_o,
  input wire logic [sra_pkg::ADDR_W-1:0] wr_addr_o,
  input wire logic [sra_pkg::WORD_W-1:0] wr_data_o,
  input wire logic cmd_reject_o,
  input wire logic wr_drop_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_oe_released: assert property (cs_n_i |-> !sdo_oe_o) else $error("sdo driven");
  a_oe_in_frame: assert property (sdo_oe_o |-> frame_active_o) else $error("oe early");
  a_frame_follow: assert property (frame_active_o == !$past(cs_n_i, 3)) else $error("frame");
  a_write_spacing: assert property (wr_valid_o |=> !wr_valid_o [*3]) else $error("valid");
  a_write_hold: assert property (!wr_valid_o |-> $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write data moved");
  a_reject_pulse: assert property (cmd_reject_o |=> !cmd_reject_o) else $error("reject");
  a_drop_pulse: assert property (wr_drop_o |=> !wr_drop_o [*3]) else $error("drop");
  a_drop_no_write: assert property (wr_drop_o |-> !wr_valid_o) else $error("drop and write");
endmodule
`default_nettype wire

/* testbench/sra_spi_master.sv */
`timescale 1ns/10ps
`default_nettype none
module sra_spi_master (
  input wire logic lk_i,
  input wire logic idle_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  logic en = 1'b0;
  logic [15:0] rword;
  logic [15:0] tx[$];
  event got;
  initial begin
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // clock stands still at the chosen idle level outside frames
  assign sclk_o = idle_i ? (lk_i | ~en) : (lk_i & en);
  task automatic shift(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      sdi_o = w[i];
      @(posedge lk_i) rword[i] = sdo_i;
      @(negedge lk_i);
    end
  endtask
  task automatic frame(input logic [15:0] cmd, input int n);
    @(negedge lk_i);
    cs_n_o = 1'b0;
    en = 1'b1;
    shift(cmd);
    repeat (n) begin
      shift(tx.size() > 0 ? tx.pop_front() : 16'h0000);
      if (cmd[10]) ->got;
    end
    cs_n_o = 1'b1;
    // idle high: hold the clock gate until it cannot make a stray edge
    if (idle_i) @(posedge lk_i);
    en = 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/sra_spi_slave_test.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module sra_spi_slave_test;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic lk = 1'b0;
  logic idle = 1'b0;
  logic cs_n, sclk, sdi, sdo_w, sdo_o, sdo_oe_o, frame_active_o, wr_valid_o, cmd_reject_o, wr_drop_o;
  logic [9:0] wr_addr_o;
  logic [15:0] wr_data_o, d0, d1, d2;
  logic [15:0] seed = 16'h835d;
  logic [25:0] wq[$];
  logic [15:0] rq[$];
  int n_errors = 0, checks_done = 0, n_rej = 0, n_drop = 0;
  always #25 mclk_i = ~mclk_i;
  initial begin
    #3;
    forever #7.5 lk = ~lk;
  end
  // released line floats up through the bench pull-up
  assign sdo_w = sdo_oe_o ? sdo_o : 1'b1;
  sra_spi_master m (.lk_i(lk), .idle_i(idle), .sdo_i(sdo_w), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
  sra_spi_slave dut (.mclk_i(mclk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .frame_active_o(frame_active_o), .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .cmd_reject_o(cmd_reject_o), .wr_drop_o(wr_drop_o));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic conclude();
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge mclk_i) begin
    if (cmd_reject_o === 1'b1) n_rej++;
    if (wr_drop_o === 1'b1) n_drop++;
    if (wr_valid_o === 1'b1) `CHK({wr_addr_o, wr_data_o}, wq.pop_front())
  end
  always @(m.got) `CHK(m.rword, rq.pop_front())
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (3) @(negedge mclk_i);
    srst_i = 1'b0;
    seed = lfsr(seed);
    d0 = seed;
    seed = lfsr(seed);
    d1 = seed;
    seed = lfsr(seed);
    d2 = seed;
    m.tx.push_back(d0);
    wq.push_back({10'h005, d0});
    m.frame(16'he005, 1);
    repeat (12) @(negedge mclk_i);
    idle = 1'b1;
    m.tx = '{d1, d2, d0};
    wq = '{{10'h3fe, d1}, {10'h3ff, d2}};
    m.frame(16'he3fe, 3);
    rq = '{d1, d2, d2};
    m.frame(16'he7fe, 3);
    repeat (12) @(negedge mclk_i);
    idle = 1'b0;
    m.tx.push_back(~d0);
    m.frame(16'hf005, 1);
    rq.push_back(16'hffff);
    m.frame(16'hf405, 1);
    rq.push_back(d0);
    m.frame(16'he405, 1);
    repeat (12) @(negedge mclk_i);
    `CHK(n_rej, 2)
    `CHK(n_drop, 1)
    `CHK(wq.size() + rq.size(), 0)
    conclude();
  end
endmodule
bind sra_spi_slave sra_spi_monitor mon (.mclk_i(mclk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .sdo_oe_o(sdo_oe_o),
  .frame_active_o(frame_active_o), .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
  .cmd_reject_o(cmd_reject_o), .wr_drop_o(wr_drop_o));
`default_nettype wire
